// ---- rtl/mef_pkg.sv ----
// Shared constants, types and behaviour notes for the meter event/filter block
// Notes on behaviour
// - Bus trigger ORed with selected trigger sources
// - Query before serial poll answers code 0
// - After poll, query returns matching code once
// - Earliest event first, then highest priority
// - Second poll discards the queued code
// - Empty status byte makes query answer 0
// - Requests off: highest priority; newer replaces older
// - Request enable gates SRQ and serial poll, keeps queue
// - Disabling a class drops its pending events
// - Error reporting off drops syntax errors silently
// - Power-on event reported once reporting re-enabled
// - One filter enable for all functions
// - Weight per function, 1 to 99
// - Average moves by difference over weight
// - Buffer full raises event and SRQ
// - Circular buffer wrap raises no full event
// - Requests off: full event waits for query
// - Half-full occupancy raises midpoint event
// - Circular buffer raises no midpoint event
// - Init restores settings, clears all but power-on
// - Identification gives maker, model, versions, options
// - Separate enable for internal running average
package mef_pkg;
  // Register byte offsets
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_FUNC   = 8'h04;
  localparam logic [7:0] A_WEIGHT = 8'h08;
  localparam logic [7:0] A_ERRQ   = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_AVG    = 8'h14;
  localparam logic [7:0] A_CMD    = 8'h18;
  localparam logic [7:0] A_ID     = 8'h1C;
  localparam logic [7:0] A_IDOPT  = 8'h20;
  // Control register bits
  localparam int B_DEVT  = 0;
  localparam int B_SRQE  = 1;
  localparam int B_ERRST = 2;
  localparam int B_FILT  = 3;
  localparam int B_IAVG  = 4;
  localparam int B_OVER  = 5;
  localparam int B_FULL  = 6;
  localparam int B_HALF  = 7;
  localparam int B_USER  = 8;
  localparam int B_DONE  = 9;
  localparam int B_CIRC  = 10;
  localparam int CTRL_W  = 11;
  localparam logic [CTRL_W-1:0] CTRL_RST = 11'h016;
  localparam int B_INIT  = 0;
  // Event classes, index is priority (0 highest)
  localparam int C_PON  = 0;
  localparam int C_ERR  = 1;
  localparam int C_OVER = 2;
  localparam int C_FULL = 3;
  localparam int C_HALF = 4;
  localparam int C_USER = 5;
  localparam int C_DONE = 6;
  localparam int NCLS   = 7;
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_PON  = 8'h01;
  localparam logic [7:0] CODE_OVER = 8'h02;
  localparam logic [7:0] CODE_FULL = 8'h03;
  localparam logic [7:0] CODE_HALF = 8'h04;
  localparam logic [7:0] CODE_USER = 8'h05;
  localparam logic [7:0] CODE_DONE = 8'h06;
  localparam logic [7:0] STB_SRQE  = 8'h40;
  // Functions and filter weights
  localparam int FUNC_W = 3;
  localparam int NFUNC  = 8;
  localparam logic [FUNC_W-1:0] FUNC_RST = 3'h0;
  localparam int WT_W = 7;
  localparam logic [WT_W-1:0] WT_MIN = 7'h01;
  localparam logic [WT_W-1:0] WT_MAX = 7'h63;
  localparam logic [WT_W-1:0] WT_RST = 7'h01;
  localparam int RD_W = 24;

  typedef struct packed {
    logic       over;
    logic       full;
    logic       half;
    logic       user;
    logic       done;
    logic       syntax;
    logic [7:0] syntax_code;
  } mef_events_s;

  typedef struct packed {
    logic [31:0]            rdata;
    logic                   rdy;
    logic                   resp;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [CTRL_W-1:0]      ctrl;
    logic [FUNC_W-1:0]      func;
    logic [NCLS-1:0]        pend;
    logic [7:0]             err_code;
    logic [2:0]             first;
    logic                   first_v;
    logic [7:0]             queued;
    logic                   pon_held;
    logic                   srq;
    logic [7:0]             stb;
    logic                   trig;
    logic signed [RD_W-1:0] prev;
    logic signed [RD_W-1:0] avg;
    logic                   seed;
    logic                   avg_v;
  } mef_state_s;

  typedef struct packed {
    logic [NFUNC-1:0][WT_W-1:0] w;
    logic [WT_W-1:0]            rd;
  } mef_wmem_s;
endpackage

// ---- rtl/mef_weight_mem.sv ----
// Per-function filter weight store with registered read
`timescale 1ns/1ps
`default_nettype none
module mef_weight_mem (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // Write port
  input  wire logic                        we,
  input  wire logic [mef_pkg::FUNC_W-1:0]  waddr,
  input  wire logic [mef_pkg::WT_W-1:0]    wdata,
  // Read port
  input  wire logic [mef_pkg::FUNC_W-1:0]  raddr,
  output logic      [mef_pkg::WT_W-1:0]    rdata
);
  mef_pkg::mef_wmem_s m_q;
  mef_pkg::mef_wmem_s m_d;

  always_comb begin
    m_d = m_q;
    if (we) begin
      m_d.w[waddr] = wdata;
    end
    m_d.rd = m_q.w[raddr];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      m_q.w  <= {mef_pkg::NFUNC{mef_pkg::WT_RST}};
      m_q.rd <= mef_pkg::WT_RST;
    end else begin
      m_q <= m_d;
    end
  end

  assign rdata = m_q.rd;
endmodule
`default_nettype wire

// ---- rtl/mef_top.sv ----
// Event queue, status reporting, triggers and reading filter of the meter
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module mef_top #(
  // Identification fields; values are arbitrary
  parameter logic [7:0]  MAKER_CODE  = 8'hA5,
  parameter logic [7:0]  MODEL_CODE  = 8'h5A,
  parameter logic [7:0]  FORMAT_VER  = 8'h01,
  parameter logic [7:0]  FIRMWARE_VER = 8'h01,
  parameter logic [31:0] OPTION_BITS = 32'h0000_0000
) (
  // Clock and reset
  input  wire logic                         SYS_CLK,
  input  wire logic                         SRST,
  // AHB-Lite slave
  input  wire logic                         HSEL,
  input  wire logic [31:0]                  HADDR,
  input  wire logic [1:0]                   HTRANS,
  input  wire logic                         HWRITE,
  input  wire logic [2:0]                   HSIZE,
  input  wire logic [31:0]                  HWDATA,
  input  wire logic                         HREADY,
  output logic      [31:0]                  HRDATA,
  output logic                              HREADYOUT,
  output logic                              HRESP,
  // Instrument bus interface side
  input  wire logic                         GET,
  input  wire logic                         SPOLL,
  output logic                              SRQ,
  output logic      [7:0]                   STB,
  // Trigger
  input  wire logic                         TRIG_SRC,
  output logic                              TRIG,
  // Report events
  input  wire mef_pkg::mef_events_s         EVENTS,
  // Converter readings and filtered average
  input  wire logic                         CONV_VALID,
  input  wire logic signed [mef_pkg::RD_W-1:0] CONV_DATA,
  output logic signed [mef_pkg::RD_W-1:0]   AVG,
  output logic                              AVG_VALID
);
  mef_pkg::mef_state_s st_q;
  mef_pkg::mef_state_s st_d;

  logic                          addr_ph;
  logic                          rd_errq;
  logic                          mem_we;
  logic [mef_pkg::WT_W-1:0]      wt_rd;
  logic [mef_pkg::WT_W-1:0]      wr_wt;
  logic signed [mef_pkg::RD_W-1:0] conv_x;
  logic [mef_pkg::NCLS-1:0]      ev;
  logic [mef_pkg::NCLS-1:0]      pend_n;
  logic [2:0]                    sel;
  logic [mef_pkg::CTRL_W-1:0]    new_ctrl;

  // Class enables; the power-on class can never be disabled
  function automatic logic [mef_pkg::NCLS-1:0] cls_en(
    input logic [mef_pkg::CTRL_W-1:0] c);
    cls_en = {c[mef_pkg::B_DONE], c[mef_pkg::B_USER], c[mef_pkg::B_HALF],
              c[mef_pkg::B_FULL], c[mef_pkg::B_OVER], c[mef_pkg::B_ERRST],
              1'b1};
  endfunction

  // Lowest index pending is the highest priority
  function automatic logic [2:0] prio(input logic [mef_pkg::NCLS-1:0] v);
    prio = 3'h0;
    for (int i = mef_pkg::NCLS - 1; i >= 0; i--) begin
      if (v[i]) begin
        prio = 3'(i);
      end
    end
  endfunction

  function automatic logic [7:0] code_of(input logic [2:0] c,
                                         input logic [7:0] err);
    case (c)
      3'h0:    code_of = mef_pkg::CODE_PON;
      3'h1:    code_of = err;
      3'h2:    code_of = mef_pkg::CODE_OVER;
      3'h3:    code_of = mef_pkg::CODE_FULL;
      3'h4:    code_of = mef_pkg::CODE_HALF;
      3'h5:    code_of = mef_pkg::CODE_USER;
      3'h6:    code_of = mef_pkg::CODE_DONE;
      default: code_of = mef_pkg::CODE_NONE;
    endcase
  endfunction

  // Two-point running mean, kept cheap on purpose
  function automatic logic signed [mef_pkg::RD_W-1:0] mean2(
    input logic signed [mef_pkg::RD_W-1:0] a,
    input logic signed [mef_pkg::RD_W-1:0] b);
    logic signed [mef_pkg::RD_W:0] s;
    s = {a[mef_pkg::RD_W-1], a} + {b[mef_pkg::RD_W-1], b};
    mean2 = s[mef_pkg::RD_W:1];
  endfunction

  function automatic logic signed [mef_pkg::RD_W-1:0] wstep(
    input logic signed [mef_pkg::RD_W-1:0] a,
    input logic signed [mef_pkg::RD_W-1:0] x,
    input logic [mef_pkg::WT_W-1:0]        w);
    logic signed [mef_pkg::RD_W:0] diff;
    logic signed [mef_pkg::RD_W:0] q;
    diff = {x[mef_pkg::RD_W-1], x} - {a[mef_pkg::RD_W-1], a};
    q = diff / $signed({18'h0, w});
    wstep = mef_pkg::RD_W'({a[mef_pkg::RD_W-1], a} + q);
  endfunction

  // Only whole-word transfers are accepted
  assign addr_ph = HSEL & HTRANS[1] & HREADY & (HSIZE == 3'h2);
  assign rd_errq = addr_ph & ~HWRITE & (HADDR[7:0] == mef_pkg::A_ERRQ);
  assign wr_wt   = HWDATA[mef_pkg::WT_W-1:0];
  // Out-of-range weights are ignored, the old one stays
  assign mem_we  = st_q.wr_pend & (st_q.wr_addr == mef_pkg::A_WEIGHT)
                 & (HWDATA[31:mef_pkg::WT_W] == '0)
                 & (wr_wt >= mef_pkg::WT_MIN)
                 & (wr_wt <= mef_pkg::WT_MAX);
  assign conv_x  = st_q.ctrl[mef_pkg::B_IAVG]
                 ? mean2(CONV_DATA, st_q.prev) : CONV_DATA;

  // Full and half events are suppressed for a circular buffer
  assign ev = {EVENTS.done, EVENTS.user,
               EVENTS.half & ~st_q.ctrl[mef_pkg::B_CIRC],
               EVENTS.full & ~st_q.ctrl[mef_pkg::B_CIRC],
               EVENTS.over, EVENTS.syntax, 1'b0}
            & cls_en(st_q.ctrl);

  always_comb begin
    st_d        = st_q;
    pend_n      = st_q.pend;
    new_ctrl    = st_q.ctrl;
    sel         = prio(st_q.pend);
    st_d.trig   = (GET & st_q.ctrl[mef_pkg::B_DEVT]) | TRIG_SRC;
    st_d.avg_v  = 1'b0;
    st_d.wr_pend = 1'b0;

    // Reading path first, so a seed asked for by a write in the same
    // cycle is not undone by the reading
    if (CONV_VALID) begin
      st_d.prev  = CONV_DATA;
      st_d.avg_v = 1'b1;
      if (!st_q.ctrl[mef_pkg::B_FILT]) begin
        st_d.avg  = conv_x;
        st_d.seed = 1'b1;
      end else if (st_q.seed) begin
        st_d.avg  = conv_x;
        st_d.seed = 1'b0;
      end else begin
        st_d.avg = wstep(st_q.avg, conv_x, wt_rd);
      end
    end

    // Data phase of a write
    if (st_q.wr_pend) begin
      case (st_q.wr_addr)
        mef_pkg::A_CTRL: begin
          new_ctrl  = HWDATA[mef_pkg::CTRL_W-1:0];
          st_d.ctrl = new_ctrl;
          // Dropped on disable, so a later enable finds nothing
          pend_n = pend_n & ~(cls_en(st_q.ctrl) & ~cls_en(new_ctrl));
          if (new_ctrl[mef_pkg::B_FILT] & ~st_q.ctrl[mef_pkg::B_FILT]) begin
            st_d.seed = 1'b1;
          end
        end
        mef_pkg::A_FUNC: begin
          st_d.func = HWDATA[mef_pkg::FUNC_W-1:0];
          if (st_d.func != st_q.func) begin
            st_d.seed = 1'b1;
          end
        end
        mef_pkg::A_CMD: begin
          if (HWDATA[mef_pkg::B_INIT]) begin
            // Weights are saved settings and survive init
            pend_n      = pend_n & 7'h01;
            st_d.queued = mef_pkg::CODE_NONE;
            st_d.ctrl   = mef_pkg::CTRL_RST;
            st_d.func   = mef_pkg::FUNC_RST;
            st_d.stb    = mef_pkg::CODE_NONE;
            st_d.seed   = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Address phase
    if (addr_ph) begin
      st_d.wr_pend = HWRITE;
      st_d.wr_addr = HADDR[7:0];
      st_d.rdata   = 32'h0000_0000;
      if (!HWRITE) begin
        case (HADDR[7:0])
          mef_pkg::A_CTRL:   st_d.rdata = 32'(st_q.ctrl);
          mef_pkg::A_FUNC:   st_d.rdata = 32'(st_q.func);
          mef_pkg::A_WEIGHT: st_d.rdata = 32'(wt_rd);
          mef_pkg::A_ERRQ: begin
            if (st_q.ctrl[mef_pkg::B_SRQE]) begin
              // Code delivered once, then gone
              st_d.rdata  = 32'(st_q.queued);
              st_d.queued = mef_pkg::CODE_NONE;
            end else if (st_q.pend != '0) begin
              st_d.rdata  = 32'(code_of(sel, st_q.err_code));
              pend_n[sel] = 1'b0;
            end
          end
          mef_pkg::A_STATUS: st_d.rdata = {8'h00, st_q.stb, 3'h0,
                                           st_q.pon_held, st_q.first_v,
                                           st_q.first, st_q.srq, st_q.pend};
          mef_pkg::A_AVG:    st_d.rdata = 32'(st_q.avg);
          mef_pkg::A_ID:     st_d.rdata = {MAKER_CODE, MODEL_CODE,
                                           FORMAT_VER, FIRMWARE_VER};
          mef_pkg::A_IDOPT:  st_d.rdata = OPTION_BITS;
          default:           st_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Serial poll hands out one event; an unread queued code is lost
    if (SPOLL && st_q.ctrl[mef_pkg::B_SRQE]) begin
      if (st_q.pend != '0) begin
        if (st_q.first_v) begin
          sel = st_q.first;
        end
        st_d.queued = code_of(sel, st_q.err_code);
        st_d.stb    = mef_pkg::STB_SRQE | st_d.queued;
        pend_n[sel] = 1'b0;
      end else begin
        st_d.queued = mef_pkg::CODE_NONE;
        st_d.stb    = mef_pkg::CODE_NONE;
      end
    end

    if (st_q.first_v && !pend_n[st_q.first]) begin
      st_d.first_v = 1'b0;
    end

    // Sets come after clears so an arriving event is never lost
    if (ev != '0) begin
      if (pend_n == '0 && !st_d.first_v) begin
        st_d.first   = prio(ev);
        st_d.first_v = 1'b1;
      end
      if (ev[mef_pkg::C_ERR]) begin
        st_d.err_code = EVENTS.syntax_code;
      end
      pend_n = pend_n | ev;
    end

    // Power-on event waits until error reporting is on
    if (st_q.pon_held && st_d.ctrl[mef_pkg::B_ERRST]) begin
      pend_n[mef_pkg::C_PON] = 1'b1;
      st_d.pon_held = 1'b0;
    end

    st_d.pend = pend_n;
    st_d.srq  = st_d.ctrl[mef_pkg::B_SRQE] & (pend_n != '0);
  end

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      st_q          <= '0;
      st_q.rdy      <= 1'b1;
      st_q.ctrl     <= mef_pkg::CTRL_RST;
      st_q.func     <= mef_pkg::FUNC_RST;
      st_q.pon_held <= 1'b1;
      st_q.seed     <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  mef_weight_mem u_wmem (
    .clk   (SYS_CLK),
    .rst   (SRST),
    .we    (mem_we),
    .waddr (st_q.func),
    .wdata (wr_wt),
    .raddr (st_q.func),
    .rdata (wt_rd)
  );

  assign HRDATA    = st_q.rdata;
  assign HREADYOUT = st_q.rdy;
  assign HRESP     = st_q.resp;
  assign SRQ       = st_q.srq;
  assign STB       = st_q.stb;
  assign TRIG      = st_q.trig;
  assign AVG       = st_q.avg;
  assign AVG_VALID = st_q.avg_v;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  property p_trig;
    GET && st_q.ctrl[mef_pkg::B_DEVT] |=> TRIG;
  endproperty
  a_trig: assert property (p_trig)
    else $error("bus trigger not passed on");

  property p_query_zero;
    rd_errq && st_q.ctrl[mef_pkg::B_SRQE]
      && st_q.queued == mef_pkg::CODE_NONE |=> HRDATA == 32'h0;
  endproperty
  a_query_zero: assert property (p_query_zero)
    else $error("query before poll not zero");

  property p_once;
    rd_errq && st_q.ctrl[mef_pkg::B_SRQE] && !SPOLL
      |=> st_q.queued == mef_pkg::CODE_NONE;
  endproperty
  a_once: assert property (p_once)
    else $error("queued code delivered twice");

  property p_empty_poll;
    SPOLL && st_q.ctrl[mef_pkg::B_SRQE] && st_q.pend == '0 && !(ev != '0)
      |=> STB == 8'h00 && st_q.queued == mef_pkg::CODE_NONE;
  endproperty
  a_empty_poll: assert property (p_empty_poll)
    else $error("empty poll left a code");

  property p_srq;
    SRQ |-> st_q.ctrl[mef_pkg::B_SRQE] && st_q.pend != '0;
  endproperty
  a_srq: assert property (p_srq)
    else $error("SRQ without enable or event");

  property p_quiet;
    EVENTS.syntax && !st_q.ctrl[mef_pkg::B_ERRST]
      && !st_q.pend[mef_pkg::C_ERR] |=> !st_q.pend[mef_pkg::C_ERR];
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("syntax error kept while off");

  property p_pon;
    st_q.pon_held && st_q.ctrl[mef_pkg::B_ERRST] && !st_q.wr_pend
      |=> st_q.pend[mef_pkg::C_PON] && !st_q.pon_held;
  endproperty
  a_pon: assert property (p_pon)
    else $error("power-on event not reported");

  property p_circ;
    EVENTS.full && st_q.ctrl[mef_pkg::B_CIRC]
      && !st_q.pend[mef_pkg::C_FULL] |=> !st_q.pend[mef_pkg::C_FULL];
  endproperty
  a_circ: assert property (p_circ)
    else $error("full event from circular buffer");

  sequence s_seed;
    CONV_VALID && st_q.ctrl[mef_pkg::B_FILT] && st_q.seed;
  endsequence
  property p_seed;
    s_seed |=> AVG_VALID && AVG == $past(conv_x)
      && (!st_q.seed || $past(st_q.wr_pend));
  endproperty
  a_seed: assert property (p_seed)
    else $error("average not seeded");
endmodule
`default_nettype wire

// ---- verification/mef_ctl_model.sv ----
// Instrument bus controller model: device trigger messages and serial polls
`timescale 1ns/1ps
`default_nettype none
module mef_ctl_model (
  // Clock
  input  wire logic       clk,
  // Bus messages to the meter
  output logic            get,
  output logic            spoll,
  // Status byte seen by the controller
  input  wire logic [7:0] stb,
  output logic            seen,
  output logic [7:0]      stb_q
);
  initial begin
    get   = 1'b0;
    spoll = 1'b0;
    seen  = 1'b0;
    stb_q = 8'h00;
  end

  // One-cycle group execute trigger message
  task automatic send_get();
    @(posedge clk);
    get <= 1'b1;
    @(posedge clk);
    get <= 1'b0;
  endtask

  // Byte is taken one edge after the poll lands, when it has settled
  task automatic poll();
    @(posedge clk);
    spoll <= 1'b1;
    @(posedge clk);
    spoll <= 1'b0;
    @(posedge clk);
    stb_q <= stb;
    seen  <= 1'b1;
    @(posedge clk);
    seen  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/mef_top_tb.sv ----
// Self-checking bench for the meter event queue, trigger and filter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      n_errors++; \
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); \
    end \
  end
module mef_top_tb;
  logic                               SYS_CLK    = 1'b0;
  logic                               SRST       = 1'b1;
  logic                               HSEL       = 1'b0;
  logic [31:0]                        HADDR      = 32'h0;
  logic [1:0]                         HTRANS     = 2'h0;
  logic                               HWRITE     = 1'b0;
  logic [2:0]                         HSIZE      = 3'h2;
  logic [31:0]                        HWDATA     = 32'h0;
  logic                               TRIG_SRC   = 1'b0;
  logic                               CONV_VALID = 1'b0;
  logic signed [mef_pkg::RD_W-1:0]    CONV_DATA  = 24'h0;
  mef_pkg::mef_events_s               EVENTS     = '0;
  logic [31:0]                        HRDATA;
  logic                               HREADYOUT;
  logic                               HRESP;
  logic                               GET;
  logic                               SPOLL;
  logic                               SRQ;
  logic                               TRIG;
  logic                               AVG_VALID;
  logic                               seen;
  logic [7:0]                         STB;
  logic [7:0]                         stb_q;
  logic signed [mef_pkg::RD_W-1:0]    AVG;
  logic [31:0]                        exp_q[$];
  logic [7:0]                         stbs [7] = '{8'h43, 8'h6A, 8'h42,
                                                   8'h44, 8'h45, 8'h46, 8'h00};
  logic                               rd_ph = 1'b0;
  int                                 n_errors = 0;
  int                                 compares = 0;
  int                                 ntrig = 0;
  int                                 acc = 0;
  int                                 prv = 0;
  int                                 x;

  always #10 SYS_CLK = ~SYS_CLK;

  // Identity values are arbitrary
  mef_top #(.MAKER_CODE(8'h3C), .MODEL_CODE(8'hC3), .FORMAT_VER(8'h02),
            .FIRMWARE_VER(8'h07), .OPTION_BITS(32'h0000_0011)) i_mef_top (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .GET(GET), .SPOLL(SPOLL), .SRQ(SRQ), .STB(STB),
    .TRIG_SRC(TRIG_SRC), .TRIG(TRIG), .EVENTS(EVENTS),
    .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA), .AVG(AVG),
    .AVG_VALID(AVG_VALID));

  mef_ctl_model i_mef_ctl_model (
    .clk(SYS_CLK), .get(GET), .spoll(SPOLL), .stb(STB), .seen(seen),
    .stb_q(stb_q));

  task automatic summarize();
    $display("n_errors=%0d compares=%0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Slave may stretch a phase; the wait is bounded all the same
  task automatic hwait();
    int k;
    k = 0;
    @(posedge SYS_CLK);
    while (HREADYOUT !== 1'b1 && k < 20) begin
      @(posedge SYS_CLK);
      k++;
    end
    if (k == 20) begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HSIZE  <= 3'h2;
    hwait();
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rd_ph  <= ~w;
    hwait();
    rd_ph  <= 1'b0;
    `CHK(HRESP, 1'b0)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic pl(input logic [7:0] e);
    exp_q.push_back({24'h0, e});
    i_mef_ctl_model.poll();
  endtask

  // Bits: over, full, half, user, done, syntax, code[7:0]
  task automatic ev(input logic [13:0] e);
    @(posedge SYS_CLK);
    EVENTS <= mef_pkg::mef_events_s'(e);
    @(posedge SYS_CLK);
    EVENTS <= '0;
  endtask

  // Mode 0 seeds, 1 weighted update, 2 two-sample mean with filter off
  task automatic filt(input int w, input int mode);
    x = int'($urandom_range(2000)) - 1000;
    if (mode == 2)
      acc = (x + prv) >>> 1;
    else if (mode == 0)
      acc = x;
    else
      acc = acc + (x - acc) / w;
    prv = x;
    exp_q.push_back(32'(acc));
    @(posedge SYS_CLK);
    CONV_VALID <= 1'b1;
    CONV_DATA  <= 24'(x);
    @(posedge SYS_CLK);
    CONV_VALID <= 1'b0;
  endtask

  // An empty queue yields a value no result can carry
  task automatic pop_cmp(input logic [31:0] got);
    logic [31:0] e;
    e = 32'hDEAD_BEEF;
    if (exp_q.size() != 0)
      e = exp_q.pop_front();
    `CHK(got, e)
  endtask

  always @(posedge SYS_CLK) begin
    if (rd_ph === 1'b1)
      pop_cmp(HRDATA);
    if (seen === 1'b1)
      pop_cmp({24'h0, stb_q});
    if (AVG_VALID === 1'b1)
      pop_cmp({{8{AVG[23]}}, AVG});
    if (TRIG === 1'b1)
      ntrig++;
  end

  initial begin
    #1_000_000;
    n_errors++;
    summarize();
  end

  initial begin
    void'($urandom(62));
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    rd(mef_pkg::A_ERRQ, 32'h0);
    `CHK(SRQ, 1'b1)
    pl(8'h41);
    rd(mef_pkg::A_ERRQ, 32'h1);
    rd(mef_pkg::A_ERRQ, 32'h0);
    // Earliest event first, then by priority; each poll drops the last code
    wr(mef_pkg::A_CTRL, 32'h3F6);
    ev(14'h1000);
    ev(14'h2F2A);
    rd(mef_pkg::A_STATUS, 32'h0041_0BFE);
    foreach (stbs[i]) begin
      pl(stbs[i]);
      if (i == 1)
        rd(mef_pkg::A_ERRQ, 32'h2A);
    end
    rd(mef_pkg::A_ERRQ, 32'h0);
    // Requests off: queries pop by priority, newest error kept
    wr(mef_pkg::A_CTRL, 32'h3F4);
    ev(14'h0111);
    ev(14'h0312);
    ev(14'h1800);
    repeat (2) @(posedge SYS_CLK);
    `CHK(SRQ, 1'b0)
    wr(mef_pkg::A_CTRL, 32'h3F6);
    repeat (2) @(posedge SYS_CLK);
    `CHK(SRQ, 1'b1)
    wr(mef_pkg::A_CTRL, 32'h3F4);
    rd(mef_pkg::A_ERRQ, 32'h12);
    rd(mef_pkg::A_ERRQ, 32'h3);
    rd(mef_pkg::A_ERRQ, 32'h4);
    rd(mef_pkg::A_ERRQ, 32'h6);
    rd(mef_pkg::A_ERRQ, 32'h0);
    // Circular buffer, class disable and muted error reports lose events
    wr(mef_pkg::A_CTRL, 32'h7F4);
    ev(14'h1800);
    wr(mef_pkg::A_CTRL, 32'h3F4);
    ev(14'h0400);
    wr(mef_pkg::A_CTRL, 32'h2F4);
    wr(mef_pkg::A_CTRL, 32'h3F0);
    ev(14'h0133);
    wr(mef_pkg::A_CTRL, 32'h3F4);
    rd(mef_pkg::A_ERRQ, 32'h0);
    ev(14'h2000);
    wr(mef_pkg::A_CMD, 32'h1);
    rd(mef_pkg::A_CTRL, 32'h16);
    rd(mef_pkg::A_ERRQ, 32'h0);
    pl(8'h00);
    // Bus trigger only counts while enabled
    i_mef_ctl_model.send_get();
    wr(mef_pkg::A_CTRL, 32'h17);
    i_mef_ctl_model.send_get();
    @(posedge SYS_CLK);
    TRIG_SRC <= 1'b1;
    @(posedge SYS_CLK);
    TRIG_SRC <= 1'b0;
    repeat (2) @(posedge SYS_CLK);
    `CHK(ntrig, 2)
    // Weights live per function; out-of-range writes are refused
    wr(mef_pkg::A_FUNC, 32'h3);
    rd(mef_pkg::A_FUNC, 32'h3);
    wr(mef_pkg::A_WEIGHT, 32'h2);
    wr(mef_pkg::A_FUNC, 32'h2);
    wr(mef_pkg::A_WEIGHT, 32'h63);
    wr(mef_pkg::A_WEIGHT, 32'h64);
    repeat (2) @(posedge SYS_CLK);
    rd(mef_pkg::A_WEIGHT, 32'h63);
    wr(mef_pkg::A_WEIGHT, 32'h4);
    wr(mef_pkg::A_CTRL, 32'h0A);
    filt(4, 0);
    repeat (5) filt(4, 1);
    wr(mef_pkg::A_FUNC, 32'h3);
    filt(2, 0);
    filt(2, 1);
    wr(mef_pkg::A_CTRL, 32'h12);
    repeat (2) filt(1, 2);
    rd(mef_pkg::A_AVG, 32'(acc));
    rd(mef_pkg::A_ID, 32'h3CC3_0207);
    rd(mef_pkg::A_IDOPT, 32'h0000_0011);
    rd(8'h24, 32'h0);
    repeat (3) @(posedge SYS_CLK);
    summarize();
  end
endmodule
`default_nettype wire
